// [acs_scan_ctrl.sv]
`timescale 1ns/1ps
module acs_scan_ctrl #(
   parameter int NGRP = 4,
   parameter int NCH = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   output logic irq_o
);
   localparam int NSLOT = NGRP * NCH;
   localparam int SW = $clog2(NSLOT);
   localparam int RW = acs_pkg::RES_W;

   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_WAIT = 2'b01,
      ACS_CONV = 2'b11
   } acs_state_t;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] bresp;
      logic [acs_pkg::DIV_W-1:0] div;
      logic glob_wfr;
      logic glob_fce;
      logic scan_en;
      logic scan_cont;
      logic [NSLOT-1:0] scan_mask;
      logic [NSLOT-1:0][4:0] chctl;
      logic [NGRP-1:0][3:0] sync;
      logic [RW-1:0] sample;
      logic [RW-1:0] glob_res;
      logic glob_cmp;
      logic glob_valid;
      logic [NSLOT-1:0][RW-1:0] grp_res;
      logic [NSLOT-1:0] grp_cmp;
      logic [NSLOT-1:0] grp_valid;
      acs_state_t st;
      logic [SW-1:0] slot;
      logic first;
      logic [3:0] steps;
      logic [acs_pkg::IRQ_W-1:0] irq_sts;
      logic [acs_pkg::IRQ_W-1:0] irq_msk;
      logic irq;
   } acs_state_all_t;

   acs_state_all_t s_q, s_d;
   logic [NGRP-1:0] grp_tick;
   logic [NGRP-1:0] grp_run;

   ////////////////////////////////////////////////////////////////////////
   // group prescalers

   // slaves with any sync source other than 00 run when master zero is on
   always_comb
   begin
      for (int g = 0; g < NGRP; g++)
      begin
         if (s_q.sync[g][3:2] == acs_pkg::SYNC_SOURCE_SELECT_MASTER)
         begin
            grp_run[g] = s_q.sync[g][1:0] == acs_pkg::ANON_ON;
         end
         else
         begin
            grp_run[g] = s_q.sync[0][1:0] == acs_pkg::ANON_ON;
         end
      end
   end

   for (genvar g = 0; g < NGRP; g++)
   begin : g_pre
      acs_prescaler #(.DIV_W(acs_pkg::DIV_W)) u_pre (
         .ref_clk_i(ref_clk_i),
         .rst_i(rst_i),
         .run_i(grp_run[g]),
         .div_i(s_q.div),
         .tick_o(grp_tick[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   function automatic logic [SW-1:0] next_slot(input logic [SW-1:0] cur, input logic [NSLOT-1:0] m,
                                                 output logic wrapped);
      logic [SW-1:0] s;
      s = cur;
      wrapped = 1'b0;
      for (int i = 0; i < NSLOT; i++)
      begin
         if (s == '0)
         begin
            s = SW'(NSLOT - 1);
            wrapped = 1'b1;
         end
         else
         begin
            s = s - 1'b1;
         end
         if (m[s])
         begin
            return s;
         end
      end
      return s;
   endfunction

   always_comb
   begin
      logic wr_go;
      logic [7:0] ra;
      logic [SW-1:0] ns;
      logic wrap;
      logic [4:0] cc;
      logic cmp;
      logic [acs_pkg::IRQ_W-1:0] ev;
      logic rd_glob;
      logic [SW-1:0] sel;
      wr_go = 1'b0;
      ra = 8'h00;
      ns = '0;
      wrap = 1'b0;
      cc = '0;
      cmp = 1'b0;
      ev = '0;
      rd_glob = 1'b0;
      sel = '0;
      s_d = s_q;

      // axi write: address and data accepted in either order
      if (s_axi_awvalid && !s_q.aw_got)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end
      wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      if (wr_go)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = 2'b00;
         unique case (s_q.awaddr)
            acs_pkg::OFS_GLOBAL_CONFIG: s_d.div = s_q.wdata[acs_pkg::DIV_LSB +: acs_pkg::DIV_W];
            acs_pkg::OFS_SHARED_RESULT_CONTROL:
            begin
               s_d.glob_wfr = s_q.wdata[acs_pkg::WFR_BIT];
               s_d.glob_fce = s_q.wdata[acs_pkg::FCE_BIT];
            end
            acs_pkg::OFS_SCAN_CONTROL:
            begin
               s_d.scan_en = s_q.wdata[acs_pkg::SCAN_EN_BIT];
               s_d.scan_cont = s_q.wdata[acs_pkg::SCAN_CONT_BIT];
               s_d.scan_mask = s_q.wdata[acs_pkg::SCAN_MASK_LSB +: NSLOT];
            end
            acs_pkg::OFS_IRQ_MASK: s_d.irq_msk = s_q.wdata[acs_pkg::IRQ_W-1:0];
            acs_pkg::OFS_SAMPLE_IN: s_d.sample = s_q.wdata[RW-1:0];
            acs_pkg::OFS_SYNC_CONTROL:
            begin
               for (int g = 0; g < NGRP; g++)
               begin
                  s_d.sync[g] = s_q.wdata[4*g +: 4];
               end
            end
            default:
            begin
               // one word per slot from the channel control base, limited to the slots built and to the eight words below the group results
               if (s_q.awaddr >= acs_pkg::OFS_CHANNEL_CONTROL && s_q.awaddr < acs_pkg::OFS_GROUP_RESULT &&
                   int'(s_q.awaddr) < int'(acs_pkg::OFS_CHANNEL_CONTROL) + 4 * NSLOT)
               begin
                  s_d.chctl[SW'(s_q.awaddr[4:2])] = s_q.wdata[4:0];
               end
               else if (s_q.awaddr != acs_pkg::OFS_IRQ_STATUS)
               begin
                  s_d.bresp = 2'b10;
               end
            end
         endcase
      end

      // axi read
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rvalid)
      begin
         ra = s_axi_araddr;
         s_d.rvalid = 1'b1;
         s_d.rresp = 2'b00;
         s_d.rdata = '0;
         unique case (ra)
            acs_pkg::OFS_GLOBAL_CONFIG: s_d.rdata[acs_pkg::DIV_W-1:0] = s_q.div;
            acs_pkg::OFS_SHARED_RESULT_CONTROL: s_d.rdata[1:0] = {s_q.glob_fce, s_q.glob_wfr};
            acs_pkg::OFS_SHARED_RESULT_REG:
            begin
               s_d.rdata[RW-1:0] = s_q.glob_res;
               s_d.rdata[acs_pkg::CMP_BIT] = s_q.glob_cmp;
               s_d.rdata[acs_pkg::VALID_BIT] = s_q.glob_valid;
               rd_glob = 1'b1;
            end
            acs_pkg::OFS_SCAN_CONTROL:
            begin
               s_d.rdata[1:0] = {s_q.scan_cont, s_q.scan_en};
               s_d.rdata[acs_pkg::SCAN_MASK_LSB +: NSLOT] = s_q.scan_mask;
            end
            acs_pkg::OFS_IRQ_STATUS: s_d.rdata[acs_pkg::IRQ_W-1:0] = s_q.irq_sts;
            acs_pkg::OFS_IRQ_MASK: s_d.rdata[acs_pkg::IRQ_W-1:0] = s_q.irq_msk;
            acs_pkg::OFS_SAMPLE_IN: s_d.rdata[RW-1:0] = s_q.sample;
            acs_pkg::OFS_SYNC_CONTROL:
            begin
               for (int g = 0; g < NGRP; g++)
               begin
                  s_d.rdata[4*g +: 4] = s_q.sync[g];
               end
            end
            default:
            begin
               if (ra >= acs_pkg::OFS_CHANNEL_CONTROL && ra < acs_pkg::OFS_GROUP_RESULT &&
                   int'(ra) < int'(acs_pkg::OFS_CHANNEL_CONTROL) + 4 * NSLOT)
               begin
                  s_d.rdata[4:0] = s_q.chctl[SW'(ra[4:2])];
               end
               else if (ra >= acs_pkg::OFS_GROUP_RESULT && int'(ra) < int'(acs_pkg::OFS_GROUP_RESULT) + 4 * NSLOT)
               begin
                  s_d.rdata[RW-1:0] = s_q.grp_res[SW'(ra[5:2])];
                  s_d.rdata[acs_pkg::CMP_BIT] = s_q.grp_cmp[SW'(ra[5:2])];
                  s_d.rdata[acs_pkg::VALID_BIT] = s_q.grp_valid[SW'(ra[5:2])];
                  s_d.grp_valid[SW'(ra[5:2])] = 1'b0;
               end
               else
               begin
                  s_d.rresp = 2'b10;
               end
            end
         endcase
      end
      if (rd_glob)
      begin
         s_d.glob_valid = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////
      // background auto-scan

      sel = s_q.slot;
      cc = s_q.chctl[sel];
      unique case (s_q.st)
         ACS_IDLE:
         begin
            if (s_q.scan_en && s_q.scan_mask != '0)
            begin
               s_d.slot = next_slot('0, s_q.scan_mask, wrap);
               s_d.first = 1'b1;
               s_d.st = ACS_WAIT;
            end
         end
         ACS_WAIT:
         begin
            // first start of each pass, after a restart or a wrap, skips the hold, matching this silicon
            if (!s_q.scan_en)
            begin
               s_d.st = ACS_IDLE;
            end
            else if (!(cc[acs_pkg::TGT_BIT] && s_q.glob_wfr && s_q.glob_valid) || s_q.first)
            begin
               s_d.st = ACS_CONV;
               s_d.steps = '0;
            end
         end
         ACS_CONV:
         begin
            if (grp_tick[sel[SW-1:$clog2(NCH)]])
            begin
               s_d.steps = s_q.steps + 1'b1;
            end
            if (s_q.steps == acs_pkg::CONV_STEPS)
            begin
               ev[acs_pkg::IRQ_SRC] = 1'b1;
               ev[acs_pkg::IRQ_RES] = 1'b1;
               if (cc[acs_pkg::TGT_BIT])
               begin
                  if (s_q.glob_fce)
                  begin
                     cmp = s_q.sample > s_q.glob_res;
                     s_d.glob_cmp = cmp;
                     // no channel event on the shared register in this step
                  end
                  else
                  begin
                     ev[acs_pkg::IRQ_LOST] = s_q.glob_valid && s_q.glob_wfr;
                     s_d.glob_res = s_q.sample;
                  end
                  s_d.glob_valid = 1'b1;
               end
               else
               begin
                  if (cc[acs_pkg::FCM_BIT])
                  begin
                     cmp = s_q.sample > s_q.grp_res[sel];
                     s_d.grp_cmp[sel] = cmp;
                     ev[acs_pkg::IRQ_CHAN] = (cmp && !s_q.grp_cmp[sel] && cc[acs_pkg::EV_HI_BIT]) ||
                                             (!cmp && s_q.grp_cmp[sel] && cc[acs_pkg::EV_LO_BIT]);
                  end
                  else
                  begin
                     s_d.grp_res[sel] = s_q.sample;
                  end
                  s_d.grp_valid[sel] = 1'b1;
               end
               ns = next_slot(s_q.slot, s_q.scan_mask, wrap);
               s_d.slot = ns;
               s_d.first = wrap;
               s_d.st = (wrap && !s_q.scan_cont) ? ACS_IDLE : ACS_WAIT;
               if (wrap && !s_q.scan_cont)
               begin
                  s_d.scan_en = 1'b0;
               end
            end
         end
         default: s_d.st = ACS_IDLE;
      endcase

      ////////////////////////////////////////////////////////////////////
      // interrupt: set wins over write-one clear
      if (wr_go && s_q.awaddr == acs_pkg::OFS_IRQ_STATUS)
      begin
         s_d.irq_sts = s_q.irq_sts & ~(s_q.wstrb[0] ? s_q.wdata[acs_pkg::IRQ_W-1:0] : {acs_pkg::IRQ_W{1'b0}});
      end
      s_d.irq_sts = s_d.irq_sts | ev;
      s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.div <= acs_pkg::DIV_RST;
         s_q.st <= ACS_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = !s_q.aw_got;
   assign s_axi_wready = !s_q.w_got;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign irq_o = s_q.irq;
endmodule

// [acs_pkg.sv]
package acs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h00;
   localparam logic [7:0] OFS_SHARED_RESULT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_SHARED_RESULT_REG = 8'h08;
   localparam logic [7:0] OFS_SCAN_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_SAMPLE_IN = 8'h18;
   localparam logic [7:0] OFS_SYNC_CONTROL = 8'h1C;
   localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h20;
   localparam logic [7:0] OFS_GROUP_RESULT = 8'h40;
   // field positions
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 5;
   localparam int WFR_BIT = 0;
   localparam int FCE_BIT = 1;
   localparam int RES_W = 12;
   localparam int CMP_BIT = 12;
   localparam int VALID_BIT = 31;
   localparam int SCAN_EN_BIT = 0;
   localparam int SCAN_CONT_BIT = 1;
   localparam int SCAN_MASK_LSB = 8;
   localparam int TGT_BIT = 0;
   localparam int RWFR_BIT = 1;
   localparam int FCM_BIT = 2;
   localparam int EV_HI_BIT = 3;
   localparam int EV_LO_BIT = 4;
   localparam int ANON_LSB = 0;
   localparam int SYNC_SOURCE_SELECT_LSB = 2;
   // interrupt status bits
   localparam int IRQ_SRC = 0;
   localparam int IRQ_RES = 1;
   localparam int IRQ_CHAN = 2;
   localparam int IRQ_LOST = 3;
   localparam int IRQ_W = 4;
   // reset value and sync control codes
   localparam logic [4:0] DIV_RST = 5'h01;
   localparam logic [1:0] ANON_ON = 2'b11;
   localparam logic [1:0] SYNC_SOURCE_SELECT_MASTER = 2'b00;
   // fixed conversion length in converter clock steps
   localparam logic [3:0] CONV_STEPS = 4'h4;
endpackage

// [acs_prescaler.sv]
`timescale 1ns/1ps
module acs_prescaler #(
   parameter int DIV_W = 5
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [DIV_W-1:0] div_i,
   // converter clock enable
   output logic tick_o
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic tick;
   } acs_pre_state_t;
   acs_pre_state_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      // counter restarts while stopped, so groups started together stay in step
      if (!run_i)
      begin
         s_d.cnt = '0;
      end
      else if (s_q.cnt >= div_i)
      begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule

// [acs_scan_ctrl_asserts.sv]
`timescale 1ns/1ps
module acs_scan_ctrl_asserts #(
   parameter int NGRP = 4,
   parameter int NCH = 4
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_wr_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data late");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_aw_once: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second address taken");
   a_w_once: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("second data taken");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2])
      else $error("write response repeated");
endmodule
bind acs_scan_ctrl acs_scan_ctrl_asserts #(.NGRP(NGRP), .NCH(NCH)) u_acs_chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [acs_scan_ctrl_tb_top.sv]
`timescale 1ns/1ps
module acs_scan_ctrl_tb_top;
   localparam int TMO = 400;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d, v;
   logic [11:0] smp;
   int n_fail = 0;
   int n_compared = 0;
   int mdl [int];
   acs_scan_ctrl #(.NGRP(2), .NCH(4)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_o(irq));
   initial
   begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   ////////////////////////////////////////////////////////////////
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   task guard(input int n);
      if (n > TMO)
      begin
         $display("Error wait expected answer seen none");
         n_fail++;
         test_done();
      end
   endtask
   // requests held until the edge that samples ready, checked a half cycle before it
   task axw(input logic [7:0] a, input logic [31:0] x, output logic [1:0] rs);
      int n;
      logic ta, tw, fin;
      n = 0;
      @(posedge ref_clk_i);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge ref_clk_i);
         ta = awvalid && awready;
         tw = wvalid && wready;
         fin = bvalid;
         rs = bresp;
         @(posedge ref_clk_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
         guard(n);
      end while (fin !== 1'b1);
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
      int n;
      logic ta, fin;
      n = 0;
      @(posedge ref_clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge ref_clk_i);
         ta = arvalid && arready;
         fin = rvalid;
         x = rdata;
         rs = rresp;
         @(posedge ref_clk_i);
         if (ta) arvalid <= 1'b0;
         n++;
         guard(n);
      end while (fin !== 1'b1);
      rready <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] x);
      axw(a, x, r);
      mdl[a] = x;
      chk("bresp", 32'h0000_0000, {30'h0, r});
   endtask
   task rdc(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      axr(a, d, r);
      chk("rresp", 32'h0000_0000, {30'h0, r});
      chk(what, e & m, d & m);
   endtask
   task poll(input int b);
      int n;
      n = 0;
      do
      begin
         axr(acs_pkg::OFS_IRQ_STATUS, d, r);
         n++;
         guard(n);
      end while (d[b] !== 1'b1);
   endtask
   task irq_is(input logic e);
      repeat (3) @(negedge ref_clk_i);
      chk("irq_o", {31'h0, e}, {31'h0, irq});
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(48017));
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rdc("divider", acs_pkg::OFS_GLOBAL_CONFIG, 32'h0000_001F, 32'h0000_0001);
      rdc("status", acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F, 32'h0000_0000);
      axr(8'hFC, d, r);
      chk("unmapped rresp", 32'h0000_0002, {30'h0, r});
      axw(8'hFC, 32'h0000_0001, r);
      chk("unmapped bresp", 32'h0000_0002, {30'h0, r});
      axw(acs_pkg::OFS_SHARED_RESULT_REG, 32'hFFFF_FFFF, r);
      chk("read-only bresp", 32'h0000_0002, {30'h0, r});
      repeat (3)
      begin
         wr(acs_pkg::OFS_IRQ_MASK, $urandom);
         rdc("mask", acs_pkg::OFS_IRQ_MASK, 32'h0000_000F, mdl[acs_pkg::OFS_IRQ_MASK]);
         wr(acs_pkg::OFS_GLOBAL_CONFIG, $urandom_range(31, 1));
         rdc("divider", acs_pkg::OFS_GLOBAL_CONFIG, 32'h0000_001F, mdl[acs_pkg::OFS_GLOBAL_CONFIG]);
      end
      wr(acs_pkg::OFS_GLOBAL_CONFIG, 32'h0000_0001);
      // group 0 master switched on, group 1 slave runs with it
      wr(acs_pkg::OFS_SYNC_CONTROL, 32'h0000_0043);
      rdc("sync", acs_pkg::OFS_SYNC_CONTROL, 32'h0000_00FF, 32'h0000_0043);
      smp = 12'($urandom_range(4094, 1));
      wr(acs_pkg::OFS_SAMPLE_IN, {20'h0, smp});
      wr(acs_pkg::OFS_CHANNEL_CONTROL + 8'h10, 32'h0000_0001);
      wr(acs_pkg::OFS_CHANNEL_CONTROL, 32'h0000_0001);
      wr(acs_pkg::OFS_SHARED_RESULT_CONTROL, 32'h0000_0001);
      wr(acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F);
      wr(acs_pkg::OFS_SCAN_CONTROL, 32'h0000_1103);
      poll(acs_pkg::IRQ_RES);
      wr(acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F);
      // room for several conversions: none may start while unread
      repeat (60) @(posedge ref_clk_i);
      rdc("held", acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F, 32'h0000_0000);
      rdc("shared", acs_pkg::OFS_SHARED_RESULT_REG, 32'h8000_0FFF, {1'b1, 19'h0, smp});
      poll(acs_pkg::IRQ_LOST);
      wr(acs_pkg::OFS_SCAN_CONTROL, 32'h0000_0000);
      repeat (60) @(posedge ref_clk_i);
      wr(acs_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      irq_is(1'b0);
      wr(acs_pkg::OFS_IRQ_MASK, 32'h0000_0008);
      irq_is(1'b1);
      wr(acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F);
      irq_is(1'b0);
      // fast compare against an empty group result, rising input
      wr(acs_pkg::OFS_SHARED_RESULT_CONTROL, 32'h0000_0002);
      wr(acs_pkg::OFS_CHANNEL_CONTROL + 8'h08, 32'h0000_000C);
      wr(acs_pkg::OFS_SCAN_CONTROL, 32'h0000_0401);
      poll(acs_pkg::IRQ_CHAN);
      rdc("group compare", acs_pkg::OFS_GROUP_RESULT + 8'h08, 32'h0000_1000, 32'h0000_1000);
      // shared target: compare bit and result events, but no channel event
      wr(acs_pkg::OFS_SAMPLE_IN, 32'h0000_0FFF);
      wr(acs_pkg::OFS_CHANNEL_CONTROL + 8'h0C, 32'h0000_001D);
      wr(acs_pkg::OFS_IRQ_STATUS, 32'h0000_000F);
      wr(acs_pkg::OFS_SCAN_CONTROL, 32'h0000_0801);
      poll(acs_pkg::IRQ_RES);
      rdc("events", acs_pkg::OFS_IRQ_STATUS, 32'h0000_0007, 32'h0000_0003);
      rdc("shared compare", acs_pkg::OFS_SHARED_RESULT_REG, 32'h0000_1000, 32'h0000_1000);
      test_done();
   end
endmodule
